// >>> sensor_fifo_and_delta_regs.sv
// Contract
// (RL1) Temp delta is newest minus previous sample
// (RL2) Delta 12-bit signed, high byte whole degrees
// (RL3) Delta fraction in low register bits 7-4
// (RL4) Delta updates in every queue mode
// (RL5) Identifier register fixed, read only
// (RL6) Status bit 7 flags overflow
// (RL7) Status bit 6 flags count above threshold
// (RL8) Flags follow condition, unaffected by reads
// (RL9) Status read clears queue interrupt source bit
// (RL10) Flags held while their condition lasts
// (RL11) Status bits 5-0 give sample count
// (RL12) Empty queue and reset give count zero
// (RL13) Read port is read only, writes ignored
// (RL14) Up to 32 samples of five bytes
// (RL15) Enabled queue reads through pressure high address
// (RL16) Enabled queue zeroes other four output addresses
// (RL17) Samples keep entering during port reads
// (RL18) Sample bytes: pressure high/mid/low, temp high/low
// (RL19) Mode: off, overwrite oldest, stop when full
// (RL20) Read oldest; pop after fifth byte, count down
// (RL21) Disable or wake flushes queue and flags
// (RL22) Overflow flag set at count 32
module sensor_fifo_and_delta_regs #(
    parameter logic [7:0] IDENTIFIER_VALUE = sensor_fifo_pkg::IDENTIFIER_DEFAULT
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // New samples
    input wire logic sample_valid_i,
    input wire logic [19:0] sample_press_i,
    input wire logic [11:0] sample_temp_i,
    // Queue setup
    input wire logic [1:0] queue_mode_i,
    input wire logic [5:0] queue_level_threshold_i,
    input wire logic standby_to_active_i,
    // Status
    output logic src_fifo_o,
    output logic queue_overflow_flag_o,
    output logic queue_level_flag_o,
    output logic [5:0] queue_sample_count_o
);

    sensor_fifo_pkg::state_t st_ff;
    sensor_fifo_pkg::state_t nxt_st;
    logic enabled;
    logic data_rd;
    logic [7:0] rd_byte;
    logic [31:0] head_sample;

    // Byte order of one sample as seen on the port
    function automatic logic [7:0] sample_byte(input logic [19:0] press, input logic [11:0] temp,
                                               input logic [2:0] idx);
        logic [7:0] b;
        b = sensor_fifo_pkg::RESET_BYTE;
        case (idx)
            3'h0: b = press[19:12];
            3'h1: b = press[11:4];
            3'h2: b = {press[3:0], 4'h0};
            3'h3: b = temp[11:4];
            3'h4: b = {temp[3:0], 4'h0};
            default: b = sensor_fifo_pkg::RESET_BYTE;
        endcase
        return b; // see (RL18)
    endfunction

    assign enabled = (queue_mode_i == sensor_fifo_pkg::MODE_WRAP) ||
                     (queue_mode_i == sensor_fifo_pkg::MODE_STOP); // see (RL19)
    assign head_sample = st_ff.mem[st_ff.head];

    always_comb
    begin
        nxt_st = st_ff;
        data_rd = 1'b0;
        rd_byte = sensor_fifo_pkg::RESET_BYTE;
        nxt_st.rvalid = reg_rd_i;

        // Writes are dropped: every register here is read only
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                sensor_fifo_pkg::ADDR_PRESS_HIGH:
                begin
                    data_rd = enabled; // see (RL15)
                    if (!enabled)
                    begin
                        rd_byte = sample_byte(st_ff.last_press, st_ff.last_temp, 3'h0);
                    end
                end
                sensor_fifo_pkg::ADDR_PRESS_MID:
                    rd_byte = enabled ? sensor_fifo_pkg::RESET_BYTE :
                              sample_byte(st_ff.last_press, st_ff.last_temp, 3'h1); // see (RL16)
                sensor_fifo_pkg::ADDR_PRESS_LOW:
                    rd_byte = enabled ? sensor_fifo_pkg::RESET_BYTE :
                              sample_byte(st_ff.last_press, st_ff.last_temp, 3'h2); // see (RL16)
                sensor_fifo_pkg::ADDR_TEMP_HIGH:
                    rd_byte = enabled ? sensor_fifo_pkg::RESET_BYTE :
                              sample_byte(st_ff.last_press, st_ff.last_temp, 3'h3); // see (RL16)
                sensor_fifo_pkg::ADDR_TEMP_LOW:
                    rd_byte = enabled ? sensor_fifo_pkg::RESET_BYTE :
                              sample_byte(st_ff.last_press, st_ff.last_temp, 3'h4); // see (RL16)
                sensor_fifo_pkg::ADDR_TEMP_DELTA_HIGH:
                    rd_byte = st_ff.temp_difference_value[11:4]; // see (RL2)
                sensor_fifo_pkg::ADDR_TEMP_DELTA_LOW:
                    rd_byte = {st_ff.temp_difference_value[3:0], 4'h0}; // see (RL3)
                sensor_fifo_pkg::ADDR_DEVICE_IDENTIFIER:
                    rd_byte = IDENTIFIER_VALUE; // see (RL5)
                sensor_fifo_pkg::ADDR_QUEUE_STATUS:
                begin
                    rd_byte = {st_ff.queue_overflow_flag, st_ff.queue_level_flag, st_ff.count}; // see (RL11)
                    nxt_st.src_fifo = 1'b0; // see (RL9)
                end
                sensor_fifo_pkg::ADDR_QUEUE_READ_PORT:
                    data_rd = 1'b1; // see (RL13)
                default:
                    rd_byte = sensor_fifo_pkg::RESET_BYTE;
            endcase
        end

        // Empty queue reads as zero and pops nothing
        if (data_rd && (st_ff.count != sensor_fifo_pkg::RESET_COUNT))
        begin
            rd_byte = sample_byte(head_sample[31:12], head_sample[11:0], st_ff.byte_idx); // see (RL20)
            if (st_ff.byte_idx == sensor_fifo_pkg::LAST_BYTE_IDX)
            begin
                nxt_st.byte_idx = sensor_fifo_pkg::RESET_BYTE_IDX; // see (RL20)
                nxt_st.head = st_ff.head + sensor_fifo_pkg::PTR_ONE;
                nxt_st.count = st_ff.count - sensor_fifo_pkg::QUEUE_ONE;
            end
            else
            begin
                nxt_st.byte_idx = st_ff.byte_idx + sensor_fifo_pkg::BYTE_IDX_ONE;
            end
        end
        if (reg_rd_i)
        begin
            nxt_st.rdata = rd_byte;
        end

        // Push after pop so a full queue being drained still takes the sample
        if (sample_valid_i)
        begin
            nxt_st.temp_difference_value = sample_temp_i - st_ff.last_temp; // see (RL1) (RL4)
            nxt_st.last_press = sample_press_i;
            nxt_st.last_temp = sample_temp_i;
            if (enabled) // see (RL17)
            begin
                if (nxt_st.count != sensor_fifo_pkg::QUEUE_FULL) // see (RL14)
                begin
                    nxt_st.mem[st_ff.tail] = {sample_press_i, sample_temp_i};
                    nxt_st.tail = st_ff.tail + sensor_fifo_pkg::PTR_ONE;
                    nxt_st.count = nxt_st.count + sensor_fifo_pkg::QUEUE_ONE;
                end
                else if (queue_mode_i == sensor_fifo_pkg::MODE_WRAP) // see (RL19)
                begin
                    // Oldest sample lost, even if half read; reading goes on at the next one's first byte
                    nxt_st.mem[st_ff.tail] = {sample_press_i, sample_temp_i};
                    nxt_st.tail = st_ff.tail + sensor_fifo_pkg::PTR_ONE;
                    nxt_st.head = nxt_st.head + sensor_fifo_pkg::PTR_ONE;
                    nxt_st.byte_idx = sensor_fifo_pkg::RESET_BYTE_IDX;
                end
            end
        end

        if (!enabled || standby_to_active_i)
        begin
            nxt_st.head = sensor_fifo_pkg::RESET_PTR; // see (RL21)
            nxt_st.tail = sensor_fifo_pkg::RESET_PTR;
            nxt_st.count = sensor_fifo_pkg::RESET_COUNT;
            nxt_st.byte_idx = sensor_fifo_pkg::RESET_BYTE_IDX;
        end

        // Flags are levels of the count, so reads cannot drop them
        nxt_st.queue_overflow_flag = (nxt_st.count == sensor_fifo_pkg::QUEUE_FULL); // see (RL6) (RL22) (RL10)
        nxt_st.queue_level_flag = (queue_level_threshold_i != sensor_fifo_pkg::LEVEL_DISABLED) &&
                                  (nxt_st.count > queue_level_threshold_i); // see (RL7) (RL8) (RL10)

        // Rising flag beats a same-cycle status read
        if ((nxt_st.queue_overflow_flag && !st_ff.queue_overflow_flag) ||
            (nxt_st.queue_level_flag && !st_ff.queue_level_flag))
        begin
            nxt_st.src_fifo = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_ff <= '0; // see (RL12)
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_o = st_ff.rdata;
    assign reg_rvalid_o = st_ff.rvalid;
    assign src_fifo_o = st_ff.src_fifo;
    assign queue_overflow_flag_o = st_ff.queue_overflow_flag;
    assign queue_level_flag_o = st_ff.queue_level_flag;
    assign queue_sample_count_o = st_ff.count;

endmodule

// >>> sensor_fifo_pkg.sv
package sensor_fifo_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_PRESS_HIGH = 8'h01;
    localparam logic [7:0] ADDR_PRESS_MID = 8'h02;
    localparam logic [7:0] ADDR_PRESS_LOW = 8'h03;
    localparam logic [7:0] ADDR_TEMP_HIGH = 8'h04;
    localparam logic [7:0] ADDR_TEMP_LOW = 8'h05;
    localparam logic [7:0] ADDR_TEMP_DELTA_HIGH = 8'h0A;
    localparam logic [7:0] ADDR_TEMP_DELTA_LOW = 8'h0B;
    localparam logic [7:0] ADDR_DEVICE_IDENTIFIER = 8'h0C;
    localparam logic [7:0] ADDR_QUEUE_STATUS = 8'h0D;
    localparam logic [7:0] ADDR_QUEUE_READ_PORT = 8'h0E;

    // Field positions in the status register
    localparam int STATUS_OVF_BIT = 7;
    localparam int STATUS_LEVEL_BIT = 6;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [5:0] RESET_COUNT = 6'h00;
    localparam logic [4:0] RESET_PTR = 5'h00;
    localparam logic [2:0] RESET_BYTE_IDX = 3'h0;
    localparam logic [19:0] RESET_PRESS = 20'h00000;
    localparam logic [11:0] RESET_TEMP = 12'h000;

    // Identifier value is arbitrary, stands in for the stored one
    localparam logic [7:0] IDENTIFIER_DEFAULT = 8'h5A;

    // Queue geometry
    localparam int QUEUE_DEPTH = 32;
    localparam logic [5:0] QUEUE_FULL = 6'h20;
    localparam logic [5:0] QUEUE_ONE = 6'h01;
    localparam logic [4:0] PTR_ONE = 5'h01;
    localparam logic [2:0] BYTE_IDX_ONE = 3'h1;
    localparam logic [2:0] LAST_BYTE_IDX = 3'h4;
    localparam logic [5:0] LEVEL_DISABLED = 6'h00;

    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_WRAP = 2'h1,
        MODE_STOP = 2'h2,
        MODE_UNUSED = 2'h3
    } queue_mode_t;

    typedef struct packed {
        logic [QUEUE_DEPTH-1:0][31:0] mem;
        logic [4:0] head;
        logic [4:0] tail;
        logic [5:0] count;
        logic [2:0] byte_idx;
        logic [19:0] last_press;
        logic [11:0] last_temp;
        logic [11:0] temp_difference_value;
        logic queue_overflow_flag;
        logic queue_level_flag;
        logic src_fifo;
        logic [7:0] rdata;
        logic rvalid;
    } state_t;

endpackage

// >>> sensor_fifo_and_delta_regs_monitor.sv
module sensor_fifo_and_delta_regs_monitor (
    // Inputs
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [1:0] queue_mode_i,
    input wire logic [5:0] queue_level_threshold_i,
    input wire logic standby_to_active_i,
    // Outputs
    input wire logic reg_rvalid_o,
    input wire logic src_fifo_o,
    input wire logic queue_overflow_flag_o,
    input wire logic queue_level_flag_o,
    input wire logic [5:0] queue_sample_count_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_rvalid_after_read: assert property (1'b1 |=> reg_rvalid_o == $past(reg_rd_i))
        else $error("rvalid not one cycle after read");
    a_overflow_at_full: assert property (queue_overflow_flag_o == (queue_sample_count_o == 6'h20))
        else $error("overflow flag wrong");
    a_count_max: assert property (queue_sample_count_o <= 6'h20)
        else $error("count above 32");
    a_level_over_threshold: assert property ($stable(queue_level_threshold_i) |->
        queue_level_flag_o == (queue_level_threshold_i != 6'h00 && queue_sample_count_o > queue_level_threshold_i))
        else $error("level flag wrong");
    a_flush_clears_all: assert property (queue_mode_i[1] == queue_mode_i[0] || standby_to_active_i |=>
        queue_sample_count_o == 6'h00 && !queue_overflow_flag_o && !queue_level_flag_o)
        else $error("flush left state");
    a_src_on_rise: assert property ($rose(queue_overflow_flag_o) || $rose(queue_level_flag_o) |-> src_fifo_o)
        else $error("src not set");
    a_status_read_clears: assert property (reg_rd_i && reg_addr_i == sensor_fifo_pkg::ADDR_QUEUE_STATUS |=>
        src_fifo_o == ($rose(queue_overflow_flag_o) || $rose(queue_level_flag_o)))
        else $error("src not cleared by status read");
    a_src_needs_rise: assert property ($rose(src_fifo_o) |-> $rose(queue_overflow_flag_o) || $rose(queue_level_flag_o))
        else $error("src set without flag rise");
endmodule

bind sensor_fifo_and_delta_regs sensor_fifo_and_delta_regs_monitor i_sensor_fifo_and_delta_regs_monitor (.*);

// >>> reg_host_model.sv
module reg_host_model (
    // Bus
    input wire logic ref_clk_i,
    input wire logic reg_rvalid_i,
    input wire logic [7:0] reg_rdata_i,
    output logic reg_rd_o = 1'b0,
    output logic [7:0] reg_addr_o = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released address is inverted so a stale value cannot pass
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= a;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rvalid_i ? reg_rdata_i : 8'hXX;
    endtask
endmodule

// >>> sensor_fifo_and_delta_regs_tb.sv
module sensor_fifo_and_delta_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic reg_rd_i;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic sample_valid_i = 1'b0;
    logic [19:0] sample_press_i = 20'h00000;
    logic [11:0] sample_temp_i = 12'h000;
    logic [1:0] queue_mode_i = 2'h0;
    logic [5:0] queue_level_threshold_i = 6'h00;
    logic standby_to_active_i = 1'b0;
    logic src_fifo_o;
    logic queue_overflow_flag_o;
    logic queue_level_flag_o;
    logic [5:0] queue_sample_count_o;
    logic [31:0] q[$];
    logic [31:0] seed = 32'hE86A;
    logic [11:0] last_t = 12'h000;
    logic [11:0] dlt = 12'h000;
    logic [7:0] got;
    int bad_count = 0;
    int n_checks = 0;

    sensor_fifo_and_delta_regs i_sensor_fifo_and_delta_regs (.*);
    reg_host_model i_reg_host_model (
        .ref_clk_i(ref_clk_i),
        .reg_rvalid_i(reg_rvalid_o),
        .reg_rdata_i(reg_rdata_o),
        .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i)
    );

    always #5 ref_clk_i = ~ref_clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Sample packed as pressure then temperature
    function automatic logic [7:0] byte_of(input logic [31:0] s, input int i);
        logic [39:0] b;
        b = {s[31:16], s[15:12], 4'h0, s[11:4], s[3:0], 4'h0};
        return b[39 - 8 * i -: 8];
    endfunction

    function automatic logic [7:0] stat();
        return {q.size() == 32, queue_level_threshold_i != 6'h00 && q.size() > queue_level_threshold_i,
            6'(q.size())};
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        i_reg_host_model.read(a, got);
        chk(n, e, got);
    endtask

    task automatic push();
        seed = lfsr(seed);
        @(posedge ref_clk_i);
        sample_valid_i <= 1'b1;
        sample_press_i <= seed[31:12];
        sample_temp_i <= seed[11:0];
        @(posedge ref_clk_i);
        sample_valid_i <= 1'b0;
        dlt = seed[11:0] - last_t;
        last_t = seed[11:0];
        if (queue_mode_i == 2'h1 && q.size() == 32)
            q.pop_front();
        if (queue_mode_i[0] != queue_mode_i[1] && q.size() < 32)
            q.push_back(seed);
    endtask

    // Empty port reads give zero and pop nothing
    task automatic pop5(input logic [7:0] a);
        for (int i = 0; i < 5; i++)
            rd_chk("fifo byte", a, q.size() > 0 ? byte_of(q[0], i) : 8'h00);
        if (q.size() > 0)
            q.pop_front();
    endtask

    task automatic set_mode(input logic [1:0] m, input logic [5:0] t);
        @(posedge ref_clk_i);
        queue_mode_i <= m;
        queue_level_threshold_i <= t;
        if (m[0] == m[1])
            q.delete();
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rd_chk("status", 8'h0D, 8'h00);
        rd_chk("ident", 8'h0C, sensor_fifo_pkg::IDENTIFIER_DEFAULT);
        rd_chk("unmapped", 8'h3F, 8'h00);
        for (int m = 1; m < 3; m++)
        begin
            set_mode(m == 2 ? 2'h3 : 2'h0, 6'h00);
            repeat (3) push();
            rd_chk("delta hi", 8'h0A, dlt[11:4]);
            rd_chk("delta lo", 8'h0B, {dlt[3:0], 4'h0});
            set_mode(2'(m), 6'h04);
            repeat (34) push();
            #1 chk("src", 8'h01, {7'h00, src_fifo_o});
            rd_chk("status", 8'h0D, stat());
            rd_chk("status", 8'h0D, stat());
            chk("src", 8'h00, {7'h00, src_fifo_o});
            rd_chk("delta lo", 8'h0B, {dlt[3:0], 4'h0});
            pop5(8'h01);
            fork
                push();
                pop5(8'h01);
            join
            for (logic [7:0] a = 8'h02; a < 8'h06; a++)
                rd_chk("alias", a, 8'h00);
            @(posedge ref_clk_i);
            reg_wr_i <= 1'b1;
            reg_wdata_i <= seed[7:0];
            @(posedge ref_clk_i);
            reg_wr_i <= 1'b0;
            rd_chk("status", 8'h0D, stat());
            repeat (33) pop5(8'h0E);
            rd_chk("status", 8'h0D, 8'h00);
        end
        repeat (3) push();
        @(posedge ref_clk_i);
        standby_to_active_i <= 1'b1;
        @(posedge ref_clk_i);
        standby_to_active_i <= 1'b0;
        q.delete();
        rd_chk("status", 8'h0D, 8'h00);
        report_and_stop();
    end
endmodule
